// >>> include/endpoint_ram_transfer_pkg.sv
// constants and types of the endpoint/RAM transfer engine
// assumes an 8-bit I/O register port and a 12-bit byte-wide RAM port
package endpoint_ram_transfer_pkg;

    // register offsets on the I/O port
    localparam logic [7:0]  CTRL_OFFSET      = 8'hEA;
    localparam logic [7:0]  PTR_LOW_OFFSET   = 8'hEB;
    localparam logic [7:0]  PTR_HIGH_OFFSET  = 8'hEC;
    localparam logic [7:0]  COUNT_OFFSET     = 8'hED;

    // control/status field positions
    localparam int          RUN_BIT          = 0;
    localparam int          DIR_BIT          = 1;
    localparam int          ERR_BIT          = 2;
    localparam int          EPS_LSB          = 4;
    localparam int          EPS_MSB          = 6;
    localparam int          PTR_HIGH_MSB     = 3;
    localparam int          COUNT_MSB        = 6;

    // reset values
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  PTR_LOW_RESET    = 8'h00;
    localparam logic [7:0]  PTR_HIGH_RESET   = 8'h01;
    localparam logic [6:0]  COUNT_RESET      = 7'h00;

    // permitted RAM window and endpoint limits
    localparam logic [11:0] WINDOW_LOW       = 12'h100;
    localparam logic [11:0] WINDOW_HIGH      = 12'h8FF;
    localparam logic [2:0]  EPS_MAX_LEGAL    = 3'h4;
    localparam logic [7:0]  EP0_SIZE         = 8'h40;
    localparam logic [7:0]  EP_DOUBLE_SIZE   = 8'h80;
    localparam logic [7:0]  EP_SMALL_SIZE    = 8'h08;
    localparam logic [2:0]  EP_SMALL_FIRST   = 3'h4;

    // data buffer between source and sink
    localparam int          BUF_DEPTH        = 2;
    localparam logic [1:0]  BUF_FULL         = 2'h2;

    typedef enum logic {IDLE_ST, MOVE_ST} phase_type;

    typedef struct packed {
        logic [2:0] eps;
        logic       err;
        logic       dir;
        logic       run;
    } ctrl_type;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } ram_req_type;

    typedef struct packed {
        logic [2:0] sel;
        logic [6:0] index;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } ep_req_type;

    typedef struct packed {
        phase_type                      phase;
        ctrl_type                       ctrl;
        logic [11:0]                    addr;
        logic [6:0]                     count;
        logic [6:0]                     src_done;
        logic [6:0]                     snk_done;
        logic [6:0]                     ep_idx;
        logic [BUF_DEPTH-1:0][7:0]      buf_data;
        logic                           buf_wptr;
        logic                           buf_rptr;
        logic [1:0]                     buf_fill;
        logic                           sec_pulse;
    } state_type;

endpackage

// >>> hw/endpoint_ram_transfer.sv
// transfer engine between system RAM and the USB endpoint buffers
// assumes RAM and endpoint read data follow the address in the same cycle,
// and that the CPU issues no register access while halted
`timescale 1ns/10ps

module endpoint_ram_transfer
    import endpoint_ram_transfer_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        usb_enable,
    input  wire logic        usb_int_enable,
    input  wire logic        sec_int_mask,
    input  wire logic [7:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_we,
    output logic      [7:0]  io_rdata,
    output logic             cpu_halt,
    output logic             usb_irq,
    output logic             sec_irq,
    output ram_req_type      ram_req,
    input  wire logic [7:0]  ram_rdata,
    input  wire logic        ram_ready,
    output ep_req_type       ep_req,
    input  wire logic [7:0]  ep_rdata,
    input  wire logic        ep_ready
);

    state_type   s_reg;
    state_type   s_next;
    logic        launch;
    logic        push;
    logic        pop;
    logic        sink_ready;
    logic [7:0]  src_byte;

    // endpoint buffer size in bytes
    // endpoint sizes
    function automatic logic [7:0] ep_capacity(input logic [2:0] eps);
        logic [7:0] size;
        size = EP_DOUBLE_SIZE;
        if (eps == 3'h0)
        begin
            size = EP0_SIZE;
        end
        else if (eps >= EP_SMALL_FIRST)
        begin
            size = EP_SMALL_SIZE;
        end
        return size;
    endfunction

    // any reason to refuse a launch
    function automatic logic launch_fault(input logic [2:0]  eps,
                                          input logic [11:0] base,
                                          input logic [6:0]  count);
        logic [12:0] last;
        logic        bad;
        last = {1'b0, base} + {6'h00, count} - 13'h0001;
        bad  = 1'b0;
        if (count == 7'h00 || eps > EPS_MAX_LEGAL)
        begin
            bad = 1'b1;
        end
        if (base < WINDOW_LOW || base > WINDOW_HIGH)
        begin
            bad = 1'b1;
        end
        if (last > {1'b0, WINDOW_HIGH})
        begin
            bad = 1'b1;
        end
        if ({1'b0, count} > ep_capacity(eps))
        begin
            bad = 1'b1;
        end
        return bad;
    endfunction

    // no register writes while a copy runs
    assign launch = usb_enable && io_we && io_addr == CTRL_OFFSET
                    && io_wdata[RUN_BIT] && s_reg.phase == IDLE_ST;

    // two-entry buffer between source and sink
    assign sink_ready = s_reg.ctrl.dir ? ep_ready : ram_ready;
    assign push = s_reg.phase == MOVE_ST && s_reg.src_done != s_reg.count
                  && s_reg.buf_fill != BUF_FULL;
    assign pop  = s_reg.buf_fill != 2'h0 && sink_ready;

    // source is endpoint on receive, RAM on emit
    assign src_byte = s_reg.ctrl.dir ? ram_rdata : ep_rdata;

    always_comb
    begin
        s_next = s_reg;
        s_next.sec_pulse = 1'b0;
        if (usb_enable && io_we && s_reg.phase == IDLE_ST)
        begin
            unique case (io_addr)
                CTRL_OFFSET:
                begin
                    s_next.ctrl.eps = io_wdata[EPS_MSB:EPS_LSB];
                    s_next.ctrl.dir = io_wdata[DIR_BIT];
                    if (!io_wdata[ERR_BIT])
                    begin
                        s_next.ctrl.err = 1'b0;
                    end
                    if (launch)
                    begin
                        if (launch_fault(io_wdata[EPS_MSB:EPS_LSB], s_reg.addr, s_reg.count))
                        begin
                            s_next.ctrl.err  = 1'b1;
                            s_next.sec_pulse = !sec_int_mask;
                        end
                        else
                        begin
                            s_next.ctrl.err = 1'b0;
                            s_next.ctrl.run = 1'b1;
                            s_next.phase    = MOVE_ST;
                            s_next.src_done = 7'h00;
                            s_next.snk_done = 7'h00;
                            s_next.ep_idx   = 7'h00;
                        end
                    end
                end
                PTR_LOW_OFFSET:
                begin
                    s_next.addr[7:0] = io_wdata;
                end
                PTR_HIGH_OFFSET:
                begin
                    s_next.addr[11:8] = io_wdata[PTR_HIGH_MSB:0];
                end
                COUNT_OFFSET:
                begin
                    s_next.count = io_wdata[COUNT_MSB:0];
                end
                default:
                begin
                end
            endcase
        end
        // one byte per cycle, write pointer steps on push, read pointer on pop
        if (push)
        begin
            s_next.buf_data[s_reg.buf_wptr] = src_byte;
            s_next.buf_wptr = !s_reg.buf_wptr;
            s_next.src_done = s_reg.src_done + 7'h01;
        end
        if (pop)
        begin
            s_next.buf_rptr = !s_reg.buf_rptr;
            s_next.snk_done = s_reg.snk_done + 7'h01;
        end
        s_next.buf_fill = s_reg.buf_fill + {1'b0, push} - {1'b0, pop};
        // RAM pointer advances per RAM access
        if (s_reg.ctrl.dir ? push : pop)
        begin
            s_next.addr = s_reg.addr + 12'h001;
        end
        if (s_reg.ctrl.dir ? pop : push)
        begin
            s_next.ep_idx = s_reg.ep_idx + 7'h01;
        end
        // finish with the last sink write
        if (pop && s_reg.snk_done + 7'h01 == s_reg.count)
        begin
            s_next.phase    = IDLE_ST;
            s_next.ctrl.run = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_reg           <= '0;
            s_reg.phase     <= IDLE_ST;
            s_reg.ctrl      <= CTRL_RESET[5:0];
            s_reg.addr      <= {PTR_HIGH_RESET[PTR_HIGH_MSB:0], PTR_LOW_RESET};
            s_reg.count     <= COUNT_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // CPU held for the whole copy
    assign cpu_halt = s_reg.phase == MOVE_ST;
    // error flag gated by interrupt enable
    assign usb_irq  = s_reg.ctrl.err && usb_int_enable;
    assign sec_irq  = s_reg.sec_pulse;

    // sink is RAM on receive, endpoint on emit
    always_comb
    begin
        ram_req.addr  = s_reg.addr;
        ram_req.wdata = s_reg.buf_data[s_reg.buf_rptr];
        ram_req.we    = !s_reg.ctrl.dir && pop;
        ram_req.re    = s_reg.ctrl.dir && push;
        ep_req.sel    = s_reg.ctrl.eps;
        ep_req.index  = s_reg.ep_idx;
        ep_req.wdata  = s_reg.buf_data[s_reg.buf_rptr];
        ep_req.we     = s_reg.ctrl.dir && pop;
        ep_req.re     = !s_reg.ctrl.dir && push;
    end

    always_comb
    begin
        io_rdata = 8'h00;
        if (usb_enable)
        begin
            unique case (io_addr)
                CTRL_OFFSET:
                begin
                    io_rdata = {1'b0, s_reg.ctrl.eps, 1'b0, s_reg.ctrl.err,
                                s_reg.ctrl.dir, s_reg.ctrl.run};
                end
                PTR_LOW_OFFSET:
                begin
                    io_rdata = s_reg.addr[7:0];
                end
                PTR_HIGH_OFFSET:
                begin
                    io_rdata = {4'h0, s_reg.addr[11:8]};
                end
                COUNT_OFFSET:
                begin
                    io_rdata = {1'b0, s_reg.count};
                end
                default:
                begin
                    io_rdata = 8'h00;
                end
            endcase
        end
    end

    // helper state for the checks only
    logic [11:0] base_seen;
    logic [7:0]  move_cycles;
    logic        stall_seen;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            base_seen   <= 12'h000;
            move_cycles <= 8'h00;
            stall_seen  <= 1'b0;
        end
        else if (launch)
        begin
            base_seen   <= s_reg.addr;
            move_cycles <= 8'h00;
            stall_seen  <= 1'b0;
        end
        else if (cpu_halt)
        begin
            move_cycles <= move_cycles + 8'h01;
            stall_seen  <= stall_seen || !sink_ready;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_launch_halts: assert property (launch && !launch_fault(io_wdata[EPS_MSB:EPS_LSB],
        s_reg.addr, s_reg.count) |=> cpu_halt && s_reg.ctrl.run)
        else $error("good launch did not halt the CPU");
    a_run_cleared: assert property ($fell(cpu_halt) |-> !s_reg.ctrl.run)
        else $error("run bit still set after copy");
    a_bad_select: assert property (launch && (s_reg.count == 7'h00
        || io_wdata[EPS_MSB:EPS_LSB] > EPS_MAX_LEGAL) |=> s_reg.ctrl.err && !cpu_halt)
        else $error("illegal select or zero count not flagged");
    a_base_window: assert property (launch && (s_reg.addr < WINDOW_LOW
        || s_reg.addr > WINDOW_HIGH) |=> s_reg.ctrl.err && $stable(s_reg.addr))
        else $error("base outside window not flagged");
    a_good_clears: assert property (launch && !launch_fault(io_wdata[EPS_MSB:EPS_LSB],
        s_reg.addr, s_reg.count) |=> !s_reg.ctrl.err)
        else $error("error flag not cleared on good launch");
    a_end_pointer: assert property ($fell(cpu_halt) |->
        s_reg.addr == base_seen + {5'h00, s_reg.count})
        else $error("pointer not at base plus count");
    a_count_kept: assert property (cpu_halt |=> $stable(s_reg.count))
        else $error("byte count changed during copy");
    a_copy_length: assert property ($fell(cpu_halt) && !stall_seen |->
        move_cycles == {1'b0, s_reg.count} + 8'h01)
        else $error("unstalled copy not N plus one cycles");
    a_no_readback: assert property (s_reg.ctrl.dir |-> !ep_req.re)
        else $error("endpoint read during emission");
    a_sec_fires: assert property (launch && !sec_int_mask && launch_fault(
        io_wdata[EPS_MSB:EPS_LSB], s_reg.addr, s_reg.count) |=> sec_irq ##1 !sec_irq)
        else $error("security interrupt not a single pulse");
    a_irq_level: assert property ($rose(s_reg.ctrl.err) && usb_int_enable |-> usb_irq)
        else $error("USB interrupt missing with error set");
    a_ram_step: assert property (ram_req.we || ram_req.re |=>
        s_reg.addr == $past(s_reg.addr) + 12'h001)
        else $error("RAM pointer did not advance");

    c_receive: cover property ($fell(cpu_halt) && !s_reg.ctrl.dir);
    c_emit: cover property ($fell(cpu_halt) && s_reg.ctrl.dir);
    c_fault: cover property (sec_irq);
    c_stall: cover property (cpu_halt && !sink_ready && s_reg.buf_fill == BUF_FULL);

endmodule

// >>> testbench/ram_ep_model.sv
// far-side model: byte-wide system RAM and the endpoint dual-port buffers
// assumes same-cycle read data and request structs from the transfer engine
`timescale 1ns/10ps
module ram_ep_model
    import endpoint_ram_transfer_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        stall,
    input  wire ram_req_type ram_req,
    output logic      [7:0]  ram_rdata,
    output logic             ram_ready,
    input  wire ep_req_type  ep_req,
    output logic      [7:0]  ep_rdata,
    output logic             ep_ready
);
    logic [7:0] ram_mem [0:4095];
    logic [7:0] ep_mem  [0:1023];
    logic [7:0] cyc_reg = 8'h00;

    always @(posedge ref_clk)
    begin
        cyc_reg <= cyc_reg + 8'h01;
        if (ram_req.we && ram_ready)
            ram_mem[ram_req.addr] <= ram_req.wdata;
        if (ep_req.we && ep_ready)
            ep_mem[{ep_req.sel, ep_req.index}] <= ep_req.wdata;
    end

    // odd-cycle stalls when asked, so the two-entry buffer fills up
    assign ram_ready = !(stall && cyc_reg[0]);
    assign ep_ready  = !(stall && cyc_reg[0]);
    // unread lines carry a moving pattern, never the last byte
    assign ram_rdata = ram_req.re ? ram_mem[ram_req.addr] : ~cyc_reg;
    assign ep_rdata  = ep_req.re ? ep_mem[{ep_req.sel, ep_req.index}] : cyc_reg;
endmodule

// >>> testbench/tb_endpoint_ram_transfer.sv
// self-checking bench of the endpoint/RAM transfer engine
// assumes the far-side model ram_ep_model on the RAM and endpoint ports
`timescale 1ns/10ps
module tb_endpoint_ram_transfer
    import endpoint_ram_transfer_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        usb_enable = 1'b1;
    logic        usb_int_enable = 1'b1;
    logic        sec_int_mask = 1'b0;
    logic [7:0]  io_addr = 8'h00;
    logic [7:0]  io_wdata = 8'h00;
    logic        io_we = 1'b0;
    logic        stall = 1'b0;
    logic [7:0]  io_rdata;
    logic        cpu_halt;
    logic        usb_irq;
    logic        sec_irq;
    ram_req_type ram_req;
    ep_req_type  ep_req;
    logic [7:0]  ram_rdata;
    logic [7:0]  ep_rdata;
    logic        ram_ready;
    logic        ep_ready;
    int          mismatches = 0;
    int          checks = 0;
    int          n;
    int          pulses;
    logic [11:0] f_ptr [7] = '{12'h200, 12'h200, 12'h0FF, 12'h900, 12'h8FE, 12'h200, 12'h200};
    logic [6:0]  f_cnt [7] = '{7'h00, 7'h04, 7'h01, 7'h01, 7'h03, 7'h09, 7'h41};
    logic [2:0]  f_eps [7] = '{3'h0, 3'h5, 3'h0, 3'h0, 3'h0, 3'h4, 3'h0};

    endpoint_ram_transfer i_dut (.ref_clk(ref_clk), .rstn(rstn), .usb_enable(usb_enable),
        .usb_int_enable(usb_int_enable), .sec_int_mask(sec_int_mask), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_we(io_we), .io_rdata(io_rdata), .cpu_halt(cpu_halt),
        .usb_irq(usb_irq), .sec_irq(sec_irq), .ram_req(ram_req), .ram_rdata(ram_rdata),
        .ram_ready(ram_ready), .ep_req(ep_req), .ep_rdata(ep_rdata), .ep_ready(ep_ready));
    ram_ep_model i_far (.ref_clk(ref_clk), .stall(stall), .ram_req(ram_req),
        .ram_rdata(ram_rdata), .ram_ready(ram_ready), .ep_req(ep_req),
        .ep_rdata(ep_rdata), .ep_ready(ep_ready));

    always #20 ref_clk = ~ref_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(posedge ref_clk);
        #1;
        io_we = 1'b0;
    endtask

    // read data is combinational from the address
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        io_addr = a;
        #1;
        check(16'(io_rdata), 16'(exp));
    endtask

    task automatic setup(input logic [11:0] p, input logic [6:0] c);
        wr(PTR_LOW_OFFSET, p[7:0]);
        wr(PTR_HIGH_OFFSET, {4'h0, p[11:8]});
        wr(COUNT_OFFSET, {1'b0, c});
    endtask

    task automatic ptr_check(input logic [11:0] p, input logic [6:0] c);
        rd_check(PTR_LOW_OFFSET, p[7:0]);
        rd_check(PTR_HIGH_OFFSET, {4'h0, p[11:8]});
        rd_check(COUNT_OFFSET, {1'b0, c});
    endtask

    // halted edges are counted; a write offered meanwhile is dropped after one edge
    task automatic wait_copy(output int cnt);
        cnt = 0;
        while (cpu_halt !== 1'b0 && cnt < 400)
        begin
            @(posedge ref_clk);
            #1;
            io_we = 1'b0;
            cnt++;
        end
        if (cnt >= 400)
        begin
            mismatches++;
            close_out();
        end
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        rd_check(CTRL_OFFSET, 8'h00);
        ptr_check(12'h100, 7'h00);
        rd_check(8'hEE, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 7; i++)
        begin
            sec_int_mask = (i == 6);
            wr(CTRL_OFFSET, 8'h00);
            rd_check(CTRL_OFFSET, 8'h00);
            setup(f_ptr[i], f_cnt[i]);
            wr(CTRL_OFFSET, {1'b0, f_eps[i], 4'h1});
            check(16'(cpu_halt), 16'h0);
            pulses = 0;
            repeat (3)
            begin
                pulses += int'(sec_irq === 1'b1);
                @(posedge ref_clk);
                #1;
            end
            check(16'(pulses), (i == 6) ? 16'h0 : 16'h1);
            rd_check(CTRL_OFFSET, {1'b0, f_eps[i], 4'h4});
            ptr_check(f_ptr[i], f_cnt[i]);
            check(16'(usb_irq), 16'h1);
        end
        usb_int_enable = 1'b0;
        #1;
        check(16'(usb_irq), 16'h0);
        usb_int_enable = 1'b1;
        sec_int_mask = 1'b0;
        $display("test launch faults done");

        // emit ending exactly on the window top; error written as one is cleared
        for (int k = 0; k < 4; k++)
            i_far.ram_mem[12'h8FC + k] = 8'hC0 + 8'(k);
        setup(12'h8FC, 7'h04);
        wr(CTRL_OFFSET, 8'h47);
        check(16'(cpu_halt), 16'h1);
        wait_copy(n);
        check(16'(n), 16'h5);
        rd_check(CTRL_OFFSET, 8'h42);
        ptr_check(12'h900, 7'h04);
        for (int k = 0; k < 4; k++)
            check(16'(i_far.ep_mem[{3'h4, 7'(k)}]), 16'(8'hC0 + 8'(k)));
        $display("test emit done");

        // receive 100 bytes from endpoint 1 into RAM, with a stalling RAM
        for (int k = 0; k < 100; k++)
            i_far.ep_mem[{3'h1, 7'(k)}] = 8'(k) ^ 8'h5A;
        stall = 1'b1;
        setup(12'h100, 7'h64);
        wr(CTRL_OFFSET, 8'h11);
        io_addr = PTR_LOW_OFFSET;
        io_wdata = 8'h00;
        io_we = 1'b1;
        wait_copy(n);
        stall = 1'b0;
        rd_check(CTRL_OFFSET, 8'h10);
        ptr_check(12'h164, 7'h64);
        for (int k = 0; k < 100; k++)
            check(16'(i_far.ram_mem[12'h100 + k]), 16'(8'(k) ^ 8'h5A));
        $display("test receive done");

        usb_enable = 1'b0;
        rd_check(CTRL_OFFSET, 8'h00);
        wr(PTR_LOW_OFFSET, 8'hFF);
        usb_enable = 1'b1;
        rd_check(PTR_LOW_OFFSET, 8'h64);
        $display("test module disabled done");
        close_out();
    end
endmodule
